// ### common/imt_consts.vh
`ifndef IMT_CONSTS_VH
`define IMT_CONSTS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define IMT_REG_CTRL        4'h0
`define IMT_REG_STATUS      4'h1
`define IMT_REG_RATE_DIV    4'h2
`define IMT_REG_AUX_GAIN    4'h3
`define IMT_REG_AUX_OFFS    4'h4
`define IMT_REG_AUX_SHIFT   4'h5
`define IMT_REG_GYRO_UNIT   4'h6
`define IMT_REG_CMD         4'h7
`define IMT_REG_AUX_OUT     4'h8

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define IMT_CTRL_EXT_TRIG   0
`define IMT_CTRL_SVC        1
`define IMT_CTRL_SVC_EXIT   2

// ----------------------------------------------------------------------------
// command codes written to the command register
// ----------------------------------------------------------------------------
`define IMT_CMD_RESET       8'h01
`define IMT_CMD_CONFIG      8'h02
`define IMT_CMD_PART        8'h03
`define IMT_CMD_SERIAL      8'h04
`define IMT_CMD_SVC_INIT    8'h05
`define IMT_CMD_SVC_NORMAL  8'h06

// ----------------------------------------------------------------------------
// datagram kinds
// ----------------------------------------------------------------------------
`define IMT_DG_MEAS         2'h0
`define IMT_DG_PART         2'h1
`define IMT_DG_SERIAL       2'h2
`define IMT_DG_CONFIG       2'h3

// ----------------------------------------------------------------------------
// status bits
// ----------------------------------------------------------------------------
`define IMT_STAT_STARTUP    6

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define IMT_RATE_DIV_RST    16'h0C35
`define IMT_AUX_GAIN_RST    16'h0100
`define IMT_AUX_SHIFT_RST   4'h2
`define IMT_CLK_MHZ         100
`define IMT_MAX_RATE_SPS    2000
`define IMT_GYRO_DLY_MS     5
`define IMT_GYRO_UNIT_DLY   4'h8
`define IMT_MAX_DIV         ((`IMT_CLK_MHZ * 1000000) / `IMT_MAX_RATE_SPS)
`define IMT_GYRO_DLY_SMP    ((`IMT_GYRO_DLY_MS * `IMT_MAX_RATE_SPS) / 1000)

`endif

// ### rtl/imt_top.v
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "imt_consts.vh"

module imt_top #(
    parameter SETTLE_CYC  = 20000,          // reference settle time in cycles
    parameter STARTUP_SMP = 16'h0400,       // samples flagged as start-up
    parameter SETTLE_W    = 16              // width of the settle counter
) (
    input  wire        clock_in,           // 100 MHz system clock
    input  wire        srst_in,            // synchronous reset, active high
    input  wire        reset_low_input_in, // pin reset, active low
    input  wire        external_trigger_input_in, // trigger pin, falling edge
    input  wire [3:0]  addr_in,            // register index
    input  wire [31:0] wdata_in,           // register write data
    input  wire        wr_in,              // write strobe
    input  wire        rd_in,              // read strobe
    input  wire [23:0] aux_raw_in,         // aux converter result
    input  wire        aux_raw_valid_in,   // aux result strobe
    input  wire [23:0] gyro_raw_in,        // gyro sample, two's complement
    input  wire        tx_busy_in,         // serializer sending last datagram
    output reg  [31:0] rdata_out,          // register read data
    output reg         validity_strobe_out,// sync and transmit window; only the sample tick under trigger
    output reg         dg_start_out,       // one-cycle datagram request
    output reg  [1:0]  dg_kind_out,        // kind of requested datagram
    output reg  [23:0] gyro_word_out,      // gyro word for the datagram
    output reg  [23:0] aux_word_out,       // compensated aux word
    output reg  [7:0]  status_out,         // status byte for the datagram
    output reg  [1:0]  mode_out            // 0 init, 1 normal, 2 service
);

    localparam M_INIT = 2'h0;
    localparam M_NORM = 2'h1;
    localparam M_SVC  = 2'h2;

    localparam I_SETTLE = 2'h0;
    localparam I_SYNC   = 2'h1;
    localparam I_SEND   = 2'h2;
    localparam I_WAIT   = 2'h3;

    localparam [31:0] MAX_DIV_C = `IMT_MAX_DIV;
    localparam DLY_N = `IMT_GYRO_DLY_SMP;

    // ------------------------------------------------------------------------
    // registers held by software
    // ------------------------------------------------------------------------
    reg        ext_trig;
    reg [15:0] rate_div;
    reg [15:0] aux_gain;
    reg [23:0] aux_offs;
    reg [3:0]  aux_shift;
    reg [3:0]  gyro_unit;
    reg [7:0]  cmd;
    reg        cmd_pend;

    // ------------------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------------------
    reg [SETTLE_W-1:0] settle_cnt;
    reg [1:0]  init_st;
    reg [1:0]  id_idx;
    reg [15:0] smp_cnt;
    reg        smp_tick;
    reg [15:0] startup_cnt;
    reg        startup;
    reg        trig_q;
    reg        busy;
    reg        rst_hold;
    reg [1:0]  req_kind;
    reg        req_pend;
    reg signed [39:0] aux_filt;
    reg [23:0] gyro_dly [0:DLY_N-1];
    wire [15:0] div_eff;
    wire        trig_fall;
    wire        hw_reset;
    wire signed [40:0] aux_scaled;

    // pin reset is level sensitive; pulled-up idle high is harmless
    assign hw_reset  = srst_in | ~reset_low_input_in;
    // trigger idles high, only a high to low step counts
    assign trig_fall = trig_q & ~external_trigger_input_in;
    // external trigger forces the internal rate to IMT_MAX_RATE_SPS (divider IMT_MAX_DIV), whatever rate_div holds
    assign div_eff   = ext_trig ? MAX_DIV_C[15:0] : rate_div;

    // ------------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            ext_trig  <= 1'b0;
            rate_div  <= `IMT_RATE_DIV_RST;
            aux_gain  <= `IMT_AUX_GAIN_RST;
            aux_offs  <= 24'h000000;
            aux_shift <= `IMT_AUX_SHIFT_RST;
            gyro_unit <= 4'h0;
            cmd       <= 8'h00;
            cmd_pend  <= 1'b0;
        end
        else
        begin
            if (wr_in && addr_in == `IMT_REG_CTRL)
                ext_trig <= wdata_in[`IMT_CTRL_EXT_TRIG];
            if (wr_in && addr_in == `IMT_REG_RATE_DIV && wdata_in[15:0] != 16'h0000)
                rate_div <= wdata_in[15:0];
            // filter and compensation are programmable only in service mode
            if (wr_in && mode_out == M_SVC && addr_in == `IMT_REG_AUX_GAIN)
                aux_gain <= wdata_in[15:0];
            if (wr_in && mode_out == M_SVC && addr_in == `IMT_REG_AUX_OFFS)
                aux_offs <= wdata_in[23:0];
            if (wr_in && mode_out == M_SVC && addr_in == `IMT_REG_AUX_SHIFT)
                aux_shift <= wdata_in[3:0];
            if (wr_in && addr_in == `IMT_REG_GYRO_UNIT)
                gyro_unit <= wdata_in[3:0];
            // a new command write wins over the clear of the old one
            if (wr_in && addr_in == `IMT_REG_CMD)
            begin
                cmd      <= wdata_in[7:0];
                cmd_pend <= 1'b1;
            end
            else if (cmd_pend)
                cmd_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ------------------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (srst_in)
            rdata_out <= 32'h00000000;
        else if (rd_in)
        begin
            case (addr_in)
                `IMT_REG_CTRL:      rdata_out <= {31'h0, ext_trig};
                `IMT_REG_STATUS:    rdata_out <= {20'h00000, busy, id_idx, init_st,
                                                  mode_out, startup, status_out[3:0]};
                `IMT_REG_RATE_DIV:  rdata_out <= {16'h0000, rate_div};
                `IMT_REG_AUX_GAIN:  rdata_out <= {16'h0000, aux_gain};
                `IMT_REG_AUX_OFFS:  rdata_out <= {8'h00, aux_offs};
                `IMT_REG_AUX_SHIFT: rdata_out <= {28'h0000000, aux_shift};
                `IMT_REG_GYRO_UNIT: rdata_out <= {28'h0000000, gyro_unit};
                `IMT_REG_AUX_OUT:   rdata_out <= {8'h00, aux_word_out};
                default:            rdata_out <= 32'h00000000;
            endcase
        end
        else
            rdata_out <= 32'h00000000;
    end

    // ------------------------------------------------------------------------
    // sample tick; measurement never stops, in any mode
    // ------------------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (hw_reset)
        begin
            smp_cnt  <= 16'h0000;
            smp_tick <= 1'b0;
        end
        else if (smp_cnt >= div_eff - 16'h0001)
        begin
            smp_cnt  <= 16'h0000;
            smp_tick <= 1'b1;
        end
        else
        begin
            smp_cnt  <= smp_cnt + 16'h0001;
            smp_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // gyro delay line; one stage per internal sample at the maximum rate
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DLY_N; g = g + 1)
        begin : g_dly
            always @(posedge clock_in)
            begin
                if (hw_reset)
                    gyro_dly[g] <= 24'h000000;
                else if (smp_tick)
                    gyro_dly[g] <= (g == 0) ? gyro_raw_in : gyro_dly[(g == 0) ? 0 : g - 1];
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // aux: first-order low pass, then gain (8.8 fixed) and offset
    // ------------------------------------------------------------------------
    assign aux_scaled = ($signed(aux_filt[39:16]) * $signed({1'b0, aux_gain})) >>> 8;

    always @(posedge clock_in)
    begin
        if (hw_reset)
            aux_filt <= 40'sh0000000000;
        else if (aux_raw_valid_in)
            aux_filt <= aux_filt + (($signed({aux_raw_in, 16'h0000})
                        - aux_filt) >>> aux_shift);
    end

    // ------------------------------------------------------------------------
    // mode sequencing and datagram requests
    // ------------------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (hw_reset)
        begin
            mode_out     <= M_INIT;
            init_st      <= I_SETTLE;
            settle_cnt   <= {SETTLE_W{1'b0}};
            id_idx       <= 2'h0;
            startup      <= 1'b0;
            startup_cnt  <= 16'h0000;
            trig_q       <= 1'b1;
            busy         <= 1'b0;
            rst_hold     <= 1'b0;
            req_pend     <= 1'b0;
            req_kind     <= `IMT_DG_MEAS;
            dg_start_out <= 1'b0;
            dg_kind_out  <= `IMT_DG_MEAS;
        end
        else
        begin
            trig_q       <= external_trigger_input_in;
            dg_start_out <= 1'b0;
            rst_hold     <= tx_busy_in;
            // busy ends once the serializer has shifted the last bit
            if (busy && rst_hold && !tx_busy_in)
                busy <= 1'b0;
            if (startup && smp_tick)
            begin
                if (startup_cnt == STARTUP_SMP[15:0])
                    startup <= 1'b0;
                else
                    startup_cnt <= startup_cnt + 16'h0001;
            end
            case (mode_out)
                M_INIT:
                begin
                    case (init_st)
                        I_SETTLE:
                            if (settle_cnt == SETTLE_CYC[SETTLE_W-1:0])
                                init_st <= I_SYNC;
                            else
                                settle_cnt <= settle_cnt + 1'b1;
                        // resync channels on the next sample tick
                        I_SYNC:
                            if (smp_tick)
                                init_st <= I_SEND;
                        // init datagrams ignore the trigger setting
                        I_SEND:
                            if (!busy)
                            begin
                                dg_start_out <= 1'b1;
                                dg_kind_out  <= id_idx + 2'h1;
                                busy         <= 1'b1;
                                rst_hold     <= 1'b0;
                                init_st      <= I_WAIT;
                            end
                        I_WAIT:
                            if (!busy)
                            begin
                                if (id_idx == 2'h2)
                                begin
                                    mode_out    <= M_NORM;
                                    startup     <= 1'b1;
                                    startup_cnt <= 16'h0000;
                                end
                                else
                                begin
                                    id_idx  <= id_idx + 2'h1;
                                    init_st <= I_SEND;
                                end
                            end
                        default:
                            init_st <= I_SETTLE;
                    endcase
                end
                M_NORM:
                begin
                    // commands stay live in either trigger setting
                    if (cmd_pend)
                    begin
                        if (cmd == `IMT_CMD_RESET)
                        begin
                            mode_out   <= M_INIT;
                            init_st    <= I_SETTLE;
                            settle_cnt <= {SETTLE_W{1'b0}};
                            id_idx     <= 2'h0;
                            startup    <= 1'b0;
                        end
                        else if (cmd == `IMT_CMD_CONFIG)
                        begin
                            req_pend <= 1'b1;
                            req_kind <= `IMT_DG_CONFIG;
                        end
                        else if (cmd == `IMT_CMD_PART)
                        begin
                            req_pend <= 1'b1;
                            req_kind <= `IMT_DG_PART;
                        end
                        else if (cmd == `IMT_CMD_SERIAL)
                        begin
                            req_pend <= 1'b1;
                            req_kind <= `IMT_DG_SERIAL;
                        end
                        else if (cmd == `IMT_CMD_SVC_INIT || cmd == `IMT_CMD_SVC_NORMAL)
                            mode_out <= M_SVC;
                    end
                    else if (!busy && req_pend)
                    begin
                        dg_start_out <= 1'b1;
                        dg_kind_out  <= req_kind;
                        busy         <= 1'b1;
                        rst_hold     <= 1'b0;
                        req_pend     <= 1'b0;
                    end
                    // triggered: one datagram per edge, edges while busy dropped
                    else if (ext_trig ? (trig_fall && !busy)
                                      : (smp_tick && !busy))
                    begin
                        dg_start_out <= 1'b1;
                        dg_kind_out  <= `IMT_DG_MEAS;
                        busy         <= 1'b1;
                        rst_hold     <= 1'b0;
                    end
                end
                M_SVC:
                begin
                    if (cmd_pend && cmd == `IMT_CMD_SVC_INIT)
                    begin
                        mode_out   <= M_INIT;
                        init_st    <= I_SETTLE;
                        settle_cnt <= {SETTLE_W{1'b0}};
                        id_idx     <= 2'h0;
                    end
                    else if (cmd_pend && cmd == `IMT_CMD_SVC_NORMAL)
                    begin
                        mode_out <= M_NORM;
                        startup  <= 1'b0;
                    end
                end
                default:
                    mode_out <= M_INIT;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // datagram payload words and validity strobe
    // ------------------------------------------------------------------------
    always @(posedge clock_in)
    begin
        if (hw_reset)
        begin
            gyro_word_out       <= 24'h000000;
            aux_word_out        <= 24'h000000;
            status_out          <= 8'h00;
            validity_strobe_out <= 1'b0;
        end
        else
        begin
            // latest sample, or the delay line output when gyro_unit >= 8, is frozen as payload; word is msb-first 24-bit signed
            if (smp_tick)
                gyro_word_out <= (gyro_unit >= `IMT_GYRO_UNIT_DLY) ?
                                 gyro_dly[DLY_N-1] : gyro_raw_in;
            if (smp_tick)
                aux_word_out <= aux_scaled[23:0] + aux_offs;
            status_out <= {1'b0, startup, 6'h00};
            // sync edge on the tick; under trigger it only shows the sample clock
            if (smp_tick)
                validity_strobe_out <= 1'b1;
            else if (ext_trig || (!busy && !dg_start_out))
                validity_strobe_out <= 1'b0;
        end
    end

endmodule

// ### tb/imt_checker.sv
`timescale 1ns/1ps
module imt_checker (
    input wire        clock_in,           // system clock
    input wire        srst_in,            // sync reset
    input wire        reset_low_input_in, // pin reset, low active
    input wire [3:0]  addr_in,            // register index
    input wire        rd_in,              // read strobe
    input wire        tx_busy_in,         // serializer busy
    input wire [31:0] rdata_out,          // read data
    input wire        dg_start_out,       // datagram request
    input wire [1:0]  dg_kind_out,        // datagram kind
    input wire [7:0]  status_out,         // status byte
    input wire [1:0]  mode_out            // operating mode
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // ------------------------------------------------------------------
    // mode step: init straight into normal
    // ------------------------------------------------------------------
    sequence s_enter_normal;
        mode_out == 2'h1 && $past(mode_out) == 2'h0;
    endsequence
    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside read");
    AST_UNMAPPED: assert property (rd_in && addr_in > 4'h8 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_START_PULSE: assert property (dg_start_out |=> !dg_start_out)
        else $error("datagram request longer than one cycle");
    AST_PIN_RESET: assert property (!reset_low_input_in |=>
        mode_out == 2'h0 && !dg_start_out && status_out == 8'h0)
        else $error("pin reset did not force init");
    AST_BUSY_HOLD: assert property (tx_busy_in |-> !dg_start_out)
        else $error("request while datagram in flight");
    AST_INIT_KIND: assert property (dg_start_out && mode_out == 2'h0 |-> dg_kind_out != 2'h0)
        else $error("measurement datagram in init");
    AST_KIND_HOLD: assert property (dg_start_out ##1 reset_low_input_in |-> $stable(dg_kind_out))
        else $error("datagram kind changed after request");
    AST_STARTUP: assert property (s_enter_normal |-> ##[0:4] status_out[6])
        else $error("start-up bit missing on entry to normal");
endmodule
bind imt_top imt_checker imt_checker_i (.clock_in(clock_in), .srst_in(srst_in),
    .reset_low_input_in(reset_low_input_in), .addr_in(addr_in), .rd_in(rd_in),
    .tx_busy_in(tx_busy_in), .rdata_out(rdata_out), .dg_start_out(dg_start_out),
    .dg_kind_out(dg_kind_out), .status_out(status_out), .mode_out(mode_out));

// ### tb/imt_ser_model.sv
`timescale 1ns/1ps
module imt_ser_model (
    input  wire       clock_in,    // system clock
    input  wire       dg_start_in, // datagram request
    input  wire [3:0] len_in,      // random extra length
    output wire       busy_out     // high while bits go out
);
    reg [4:0] cnt = 5'h00;
    // busy drops only after the last bit; length varies to stall the device
    always @(posedge clock_in)
    begin
        if (dg_start_in)
            cnt <= {1'b0, len_in} + 5'h04;
        else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
    end
    assign busy_out = (cnt != 5'h00);
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0, srst = 1'b1, pin_rst_n = 1'b1, trig = 1'b1;
    reg         wr = 1'b0, rd = 1'b0, aux_v = 1'b0;
    reg  [3:0]  addr = 4'h0;
    reg  [31:0] wdata = 32'h0, seed = 32'h4D513790, r;
    reg  [23:0] aux = 24'h0, gyro = 24'h0;
    reg  [7:0]  last_st;
    reg         ext_md = 1'b0;
    reg  [23:0] gyro_q = 24'h000000;
    wire [31:0] rdata;
    wire        strobe, dg_start, busy;
    wire [1:0]  kind, mode;
    wire [7:0]  stat;
    wire [23:0] gyro_word;
    reg  [1:0]  obs[$];
    reg  [7:0]  obs_st[$];
    integer     miscompares = 0, checks = 0, i;
    imt_top #(.SETTLE_CYC(50), .STARTUP_SMP(16'h0004)) imt_top_i (.clock_in(clk),
        .srst_in(srst), .reset_low_input_in(pin_rst_n), .external_trigger_input_in(trig),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .aux_raw_in(aux),
        .aux_raw_valid_in(aux_v), .gyro_raw_in(gyro), .tx_busy_in(busy), .rdata_out(rdata),
        .validity_strobe_out(strobe), .dg_start_out(dg_start), .dg_kind_out(kind),
        .gyro_word_out(gyro_word), .aux_word_out(), .status_out(stat), .mode_out(mode));
    imt_ser_model imt_ser_model_i (.clock_in(clk), .dg_start_in(dg_start),
        .len_in(seed[7:4]), .busy_out(busy));
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // ------------------------------------------------------------------
    // clock, random sensor data and datagram monitor
    // ------------------------------------------------------------------
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        seed <= xs(seed);
        gyro <= seed[23:0];
        gyro_q <= gyro;
        aux <= seed[31:8];
        aux_v <= seed[0];
        if (dg_start)
        begin
            obs.push_back(kind);
            obs_st.push_back(stat);
        end
        // free-running datagrams carry the sample of their own tick and raise the strobe
        if (dg_start && kind == 2'h0)
        begin
            checks = checks + 1;
            if ((strobe !== !ext_md) || (!ext_md && gyro_word !== gyro_q))
            begin
                miscompares = miscompares + 1;
                $display("unexpected %0t strobe %b gyro %h", $time, strobe, gyro_word);
            end
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("unexpected %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (miscompares == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task wreg(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rreg(input [3:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 r = rdata;
        end
    endtask
    // expected kind from the datagram monitor; measurement ones are skipped for others
    task wdg(input [1:0] k, input integer lim);
        integer n;
        begin
            n = 0;
            while ((obs.size() == 0 || (k != 2'h0 && obs[0] == 2'h0)) && n < lim)
            begin
                if (obs.size() != 0)
                    begin obs.pop_front(); obs_st.pop_front(); end
                @(posedge clk);
                n = n + 1;
            end
            if (n >= lim)
            begin
                chk(32'h1, 32'h0);
                wrap_up;
            end
            else
            begin
                chk(obs.pop_front(), k);
                last_st = obs_st.pop_front();
            end
        end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        #1 chk(mode, 2'h0);
        rreg(4'h2); chk(r, 32'h0C35);
        rreg(4'hF); chk(r, 32'h0);
        wreg(4'h2, 32'd200);
        for (i = 1; i < 4; i = i + 1) wdg(i, 8000);
        wdg(2'h0, 2000); chk(last_st[6], 1'b1);
        chk(mode, 2'h1);
        repeat (6) wdg(2'h0, 2000);
        chk(last_st[6], 1'b0);
        for (i = 0; i < 3; i = i + 1)
        begin
            wreg(4'h7, i + 2);
            wdg((i == 0) ? 2'h3 : i, 2000);
        end
        wreg(4'h7, 32'h1);
        for (i = 1; i < 4; i = i + 1) wdg(i, 2000);
        repeat (40) @(posedge clk);
        #1 chk(mode, 2'h1);
        // enter service and leave straight to normal while start-up is still flagged
        wreg(4'h7, 32'h6);
        wreg(4'h7, 32'h6);
        obs.delete(); obs_st.delete();
        wdg(2'h0, 2000); chk(last_st[6], 1'b0);
        wreg(4'h0, 32'h1);
        repeat (300) @(posedge clk);
        ext_md = 1'b1;
        obs.delete(); obs_st.delete();
        repeat (500) @(posedge clk);
        chk(obs.size(), 0);
        trig <= 1'b0; wdg(2'h0, 50);
        trig <= 1'b1; @(posedge clk); trig <= 1'b0;
        repeat (100) @(posedge clk);
        chk(obs.size(), 0);
        trig <= 1'b1; @(posedge clk); trig <= 1'b0; wdg(2'h0, 50);
        wreg(4'h7, 32'h2); wdg(2'h3, 2000);
        pin_rst_n <= 1'b0; @(posedge clk); pin_rst_n <= 1'b1;
        #1 chk(mode, 2'h0);
        for (i = 1; i < 4; i = i + 1) wdg(i, 60000);
        wrap_up;
    end
endmodule
